// ---- core/sep_pkg.sv ----
/*
 * Constants, command codes and state names for the serial EEPROM
 * command and protection block.
 * Assumes a single 40 MHz clock and the 64Kbit array as the base size.
 */
package sep_pkg;

	// ----------------------------------------------------------------
	// Timing and sizes
	// ----------------------------------------------------------------
	localparam int CLK_NS     = 25;
	localparam int T_WC_NS    = 10_000_000;
	localparam int WC_CYCLES  = T_WC_NS / CLK_NS;
	localparam int ADDR_W     = 13;
	localparam int PAGE_W     = 6;
	localparam int PAGE_N     = 64;
	localparam int MEM_N      = 8192;
	localparam int BUF_W      = PAGE_W + 8;
	localparam int Q64_BIT    = 11;
	localparam int Q32_BIT    = 10;
	localparam logic [ADDR_W-1:0] MASK_64K = 13'h1fff;
	localparam logic [ADDR_W-1:0] MASK_32K = 13'h0fff;
	localparam logic [2:0]        BIT_LAST = 3'h7;
	localparam logic [1:0]        FIFO_FULL = 2'h2;

	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_ENABLE_WRITE  = 8'h06;
	localparam logic [7:0] OP_DISABLE_WRITE = 8'h04;
	localparam logic [7:0] OP_READ_STATUS   = 8'h05;
	localparam logic [7:0] OP_WRITE_STATUS  = 8'h01;
	localparam logic [7:0] OP_READ          = 8'h03;
	localparam logic [7:0] OP_WRITE         = 8'h02;

	// ----------------------------------------------------------------
	// Status layout and protect codes
	// ----------------------------------------------------------------
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_LATCH_BIT = 1;
	localparam int ST_BP_LO    = 2;
	localparam int ST_BP_HI    = 3;
	localparam int ST_PPE_BIT  = 7;
	localparam logic [1:0] BP_NONE    = 2'h0;
	localparam logic [1:0] BP_QUARTER = 2'h1;
	localparam logic [1:0] BP_HALF    = 2'h2;
	localparam logic [1:0] BP_ALL     = 2'h3;
	localparam logic [1:0] Q_TOP      = 2'h3;

	typedef enum logic [3:0] {
		S_IDLE, S_OPCODE, S_EN_HELD, S_ADDR, S_READ, S_WDATA,
		S_STAT_OUT, S_STAT_IN, S_SR_HELD, S_IGNORE
	} sep_state_t;

endpackage : sep_pkg

// ---- core/sep_buf_if.sv ----
/*
 * Valid/ready carrier for page entries {offset, data}.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface sep_buf_if;
	logic                      valid;
	logic                      ready;
	logic [sep_pkg::BUF_W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : sep_buf_if
`default_nettype wire

// ---- core/sep_fifo2.sv ----
/*
 * Two-entry buffer between the serial receiver and the page loader.
 * Assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module sep_fifo2 (
	input  wire logic i_clk,
	input  wire logic i_reset,
	sep_buf_if.snk    i_fill,
	sep_buf_if.src    o_drain
);
	import sep_pkg::*;

	logic [BUF_W-1:0] slot [0:1];
	logic             wr_ptr;
	logic             rd_ptr;
	logic [1:0]       count;
	wire              push = i_fill.valid & i_fill.ready;
	wire              pop  = o_drain.valid & o_drain.ready;

	// Full and empty come straight from the occupancy count.
	assign i_fill.ready  = (count != FIFO_FULL);
	assign o_drain.valid = (count != 2'h0);
	assign o_drain.data  = slot[rd_ptr];

	// Storage needs no reset; the pointers decide what is valid.
	always_ff @(posedge i_clk)
		if (push)
			slot[wr_ptr] <= i_fill.data;

	// Pointer and occupancy bookkeeping.
	always_ff @(posedge i_clk or posedge i_reset)
		if (i_reset)
		begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end
		else
		begin
			wr_ptr <= wr_ptr ^ push;
			rd_ptr <= rd_ptr ^ pop;
			count  <= count + {1'b0, push} - {1'b0, pop};
		end
endmodule : sep_fifo2
`default_nettype wire

// ---- core/sep_prog.sv ----
/*
 * Page buffer, array storage and self-timed programming cycle.
 * Assumes the base address stays still while a cycle runs and
 * WRITE_CYCLES is at least the page size.
 */
`timescale 1ns/1ps
`default_nettype none
module sep_prog #(
	parameter int WRITE_CYCLES = sep_pkg::WC_CYCLES
) (
	input  wire logic                                   i_clk,
	input  wire logic                                   i_reset,
	sep_buf_if.snk                                      i_load,
	input  wire logic [sep_pkg::ADDR_W-sep_pkg::PAGE_W-1:0] i_base,
	input  wire logic                                   i_start,
	input  wire logic                                   i_abort,
	input  wire logic [sep_pkg::ADDR_W-1:0]             i_rd_addr,
	output logic      [7:0]                             o_rd_data,
	output logic                                        o_busy,
	output logic                                        o_done
);
	import sep_pkg::*;
	localparam int CW = $clog2(WRITE_CYCLES + 1);
	localparam logic [CW-1:0] CNT_LAST = CW'(WRITE_CYCLES - 1);
	localparam logic [CW-1:0] CNT_PAGE = CW'(PAGE_N);

	logic [7:0]        mem  [0:MEM_N-1];
	logic [7:0]        page [0:PAGE_N-1];
	logic [PAGE_N-1:0] filled;
	logic              pend;
	logic              run;
	logic [CW-1:0]     cnt;

	// Entries are taken only while idle; commits walk the page first.
	wire              load   = i_load.valid & i_load.ready;
	wire [PAGE_W-1:0] ld_idx = i_load.data[BUF_W-1:8];
	wire [PAGE_W-1:0] cm_idx = cnt[PAGE_W-1:0];
	wire              commit = run & (cnt < CNT_PAGE) & filled[cm_idx];
	assign i_load.ready = ~pend & ~run;
	assign o_busy       = pend | run;

	// Array and page storage; a read port registered every cycle.
	always_ff @(posedge i_clk)
	begin
		if (load)
			page[ld_idx] <= i_load.data[7:0];
		if (commit)
			mem[{i_base, cm_idx}] <= page[cm_idx];
		o_rd_data <= mem[i_rd_addr];
	end

	// The cycle starts once the buffer in front has drained.
	always_ff @(posedge i_clk or posedge i_reset)
		if (i_reset)
		begin
			pend   <= 1'b0;
			run    <= 1'b0;
			cnt    <= '0;
			filled <= '0;
			o_done <= 1'b0;
		end
		else
		begin
			o_done <= 1'b0;
			if (i_abort)
				filled <= '0;
			else if (load)
				filled[ld_idx] <= 1'b1;
			if (i_start)
				pend <= 1'b1;
			if (pend & ~i_load.valid)
			begin
				pend <= 1'b0;
				run  <= 1'b1;
				cnt  <= '0;
			end
			else if (run && cnt == CNT_LAST)
			begin
				run    <= 1'b0;
				filled <= '0;
				o_done <= 1'b1;
			end
			else if (run)
				cnt <= cnt + 1'b1;
		end
endmodule : sep_prog
`default_nettype wire

// ---- core/sep_eeprom.sv ----
/*
 * Serial EEPROM slave: command decoding, status and write protection,
 * sequential reads and byte or page writes.
 * Assumes pins are synchronous to i_clk, with the serial clock high and
 * low for at least three i_clk cycles each.
 */
`timescale 1ns/1ps
`default_nettype none
module sep_eeprom #(
	parameter int   WRITE_CYCLES = sep_pkg::WC_CYCLES,
	parameter logic SMALL_PART   = 1'b0
) (
	input  wire logic i_clk,
	input  wire logic i_reset,
	input  wire logic i_cs_n,
	input  wire logic i_sck,
	input  wire logic i_si,
	input  wire logic i_wp_n,
	output logic      o_so,
	output logic      o_so_oe,
	output logic      o_standby
);
	import sep_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	sep_state_t              state;
	sep_state_t              next_state;
	logic                    cs_q;
	logic                    sck_q;
	logic [2:0]              bit_cnt;
	logic [6:0]              in_sh;
	logic                    addr_second;
	logic [7:0]              addr_hi;
	logic                    is_write;
	logic [ADDR_W-1:0]       addr;
	logic                    write_enable_latch;
	logic                    block_protect_lo  = 1'b0;
	logic                    block_protect_hi  = 1'b0;
	logic                    protect_pin_enable = 1'b0;
	logic [2:0]              sr_val;
	logic                    sr_ok;
	logic                    sr_inflight;
	logic                    wr_any;
	logic                    wr_bad;
	logic [2:0]              out_cnt;
	logic [6:0]              out_sh;
	logic [7:0]              rd_data;
	logic                    busy;
	logic                    done;

	sep_buf_if fill_if ();
	sep_buf_if load_if ();

	// ----------------------------------------------------------------
	// Pin edges
	// ----------------------------------------------------------------

	// Edges of the serial clock count only while selected.
	wire sel      = ~i_cs_n;
	wire sck_rise = sel & i_sck & ~sck_q;
	wire sck_fall = sel & ~i_sck & sck_q;
	wire cs_fall  = sel & cs_q;
	wire cs_rise  = i_cs_n & ~cs_q;

	// ----------------------------------------------------------------
	// Decoding
	// ----------------------------------------------------------------

	// Whole received byte and address forming.
	wire [7:0]        in_byte   = {in_sh, i_si};
	wire              byte_done = sck_rise & (bit_cnt == BIT_LAST);
	wire [ADDR_W-1:0] mask      = SMALL_PART ? MASK_32K : MASK_64K;
	wire [ADDR_W-1:0] in_addr   = {addr_hi[ADDR_W-9:0], in_byte} & mask;
	wire [ADDR_W-1:0] next_rd   = (addr + 1'b1) & mask;
	wire [PAGE_W-1:0] page_off  = addr[PAGE_W-1:0] + 1'b1;
	wire [ADDR_W-1:0] next_page = {addr[ADDR_W-1:PAGE_W], page_off};

	// Region check on the current address.
	wire [1:0] bp      = {block_protect_hi, block_protect_lo};
	wire [1:0] quarter = SMALL_PART ? addr[Q32_BIT +: 2]
	                                : addr[Q64_BIT +: 2];
	wire in_region = (bp == BP_ALL)
	               | ((bp == BP_HALF) & quarter[1])
	               | ((bp == BP_QUARTER) & (quarter == Q_TOP));

	// Permissions: array bytes need the latch and an open region.
	wire hw_lock = ~i_wp_n & protect_pin_enable;
	wire byte_ok = write_enable_latch & ~in_region;
	wire sr_allow = write_enable_latch & ~hw_lock;

	// Status image; the busy bit comes only from the programmer.
	wire [7:0] status_byte = {protect_pin_enable, 3'h0, block_protect_hi,
	                          block_protect_lo, write_enable_latch,
	                          busy};

	// Opcode decode at the end of the first byte.
	wire op_done = (state == S_OPCODE) & byte_done;
	wire op_disable = op_done & ~busy & (in_byte == OP_DISABLE_WRITE);
	wire op_stat_wr = op_done & ~busy & (in_byte == OP_WRITE_STATUS);

	// Data bytes of a write enter the buffer when permitted.
	wire wdata_done = (state == S_WDATA) & byte_done;
	assign fill_if.valid = wdata_done & byte_ok & ~wr_bad;
	assign fill_if.data  = {addr[PAGE_W-1:0], in_byte};

	// Commit decisions on the rise of chip select.
	wire commit_enable = cs_rise & (state == S_EN_HELD);
	wire commit_write = cs_rise & (state == S_WDATA) & wr_any & ~wr_bad
	                  & (bit_cnt == 3'h0);
	wire commit_sr = cs_rise & (state == S_SR_HELD) & sr_ok & ~hw_lock;
	wire abort_write = cs_rise & (state == S_WDATA) & ~commit_write;

	// Serial output source.
	wire       out_state = (state == S_STAT_OUT) | (state == S_READ);
	wire [7:0] out_byte  = (state == S_STAT_OUT) ? status_byte : rd_data;
	wire       out_load  = sck_fall & out_state & (out_cnt == 3'h0);

	// ----------------------------------------------------------------
	// Sequence control
	// ----------------------------------------------------------------

	// Next state from the current phase of the selection.
	always_comb
	begin
		next_state = state;
		unique case (state)
			S_IDLE:
				if (cs_fall)
					next_state = S_OPCODE;
			S_OPCODE:
				if (byte_done && busy && in_byte != OP_READ_STATUS)
					next_state = S_IGNORE;
				else if (byte_done)
				begin
					case (in_byte)
						OP_ENABLE_WRITE: next_state = S_EN_HELD;
						OP_READ_STATUS:  next_state = S_STAT_OUT;
						OP_WRITE_STATUS: next_state = S_STAT_IN;
						OP_READ:         next_state = S_ADDR;
						OP_WRITE:        next_state = S_ADDR;
						default:         next_state = S_IGNORE;
					endcase
				end
			S_EN_HELD:
				if (sck_rise)
					next_state = S_IGNORE;
			S_ADDR:
				if (byte_done && addr_second)
					next_state = is_write ? S_WDATA : S_READ;
			S_STAT_IN:
				if (byte_done)
					next_state = S_SR_HELD;
			S_SR_HELD:
				if (sck_rise)
					next_state = S_IGNORE;
			S_READ, S_WDATA, S_STAT_OUT, S_IGNORE:
				next_state = state;
		endcase
		if (i_cs_n)
			next_state = S_IDLE;
	end

	// Phase register and pin history.
	always_ff @(posedge i_clk or posedge i_reset)
		if (i_reset)
		begin
			state <= S_IDLE;
			cs_q  <= 1'b1;
			sck_q <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cs_q  <= i_cs_n;
			sck_q <= i_sck;
		end

	// Input shifter, sampled on rising serial clock edges.
	always_ff @(posedge i_clk or posedge i_reset)
		if (i_reset)
		begin
			bit_cnt <= 3'h0;
			in_sh   <= 7'h00;
		end
		else if (i_cs_n || cs_fall)
			bit_cnt <= 3'h0;
		else if (sck_rise)
		begin
			bit_cnt <= bit_cnt + 1'b1;
			in_sh   <= in_byte[6:0];
		end

	// Address capture, read stepping and page stepping.
	always_ff @(posedge i_clk or posedge i_reset)
		if (i_reset)
		begin
			addr_second <= 1'b0;
			addr_hi     <= 8'h00;
			is_write    <= 1'b0;
			addr        <= '0;
		end
		else
		begin
			if (cs_fall)
				addr_second <= 1'b0;
			else if (state == S_ADDR && byte_done)
				addr_second <= 1'b1;
			if (state == S_ADDR && byte_done && !addr_second)
				addr_hi <= in_byte;
			if (op_done)
				is_write <= (in_byte == OP_WRITE);
			if (state == S_ADDR && byte_done && addr_second)
				addr <= in_addr;
			else if (wdata_done)
				addr <= next_page;
			else if (out_load && state == S_READ)
				addr <= next_rd;
		end

	// ----------------------------------------------------------------
	// Status and write tracking
	// ----------------------------------------------------------------

	// Latch: set only by a cleanly closed enable, cleared by a disable command or a finished cycle.
	always_ff @(posedge i_clk or posedge i_reset)
		if (i_reset)
			write_enable_latch <= 1'b0;
		else if (commit_enable)
			write_enable_latch <= 1'b1;
		else if (op_disable || done)
			write_enable_latch <= 1'b0;

	// Pending status value; a pin lock at the opcode or once the status byte is in cancels it.
	always_ff @(posedge i_clk or posedge i_reset)
		if (i_reset)
		begin
			sr_val      <= 3'h0;
			sr_ok       <= 1'b0;
			sr_inflight <= 1'b0;
		end
		else
		begin
			if (op_stat_wr)
				sr_ok <= sr_allow;
			else if (state == S_SR_HELD && hw_lock)
				sr_ok <= 1'b0;
			if (state == S_STAT_IN && byte_done)
				sr_val <= {in_byte[ST_PPE_BIT], in_byte[ST_BP_HI],
				           in_byte[ST_BP_LO]};
			if (commit_sr)
				sr_inflight <= 1'b1;
			else if (done)
				sr_inflight <= 1'b0;
		end

	// Nonvolatile bits: kept across reset, changed only by a finished
	// status cycle.
	always_ff @(posedge i_clk)
		if (done && sr_inflight)
		begin
			protect_pin_enable <= sr_val[2];
			block_protect_hi   <= sr_val[1];
			block_protect_lo   <= sr_val[0];
		end

	// A write sequence is spoiled if the buffer could not take a byte.
	always_ff @(posedge i_clk or posedge i_reset)
		if (i_reset)
		begin
			wr_any <= 1'b0;
			wr_bad <= 1'b0;
		end
		else if (cs_fall)
		begin
			wr_any <= 1'b0;
			wr_bad <= 1'b0;
		end
		else if (fill_if.valid)
		begin
			wr_any <= 1'b1;
			wr_bad <= wr_bad | ~fill_if.ready;
		end

	// ----------------------------------------------------------------
	// Serial output
	// ----------------------------------------------------------------

	// Output shifter, advanced on falling serial clock edges.
	always_ff @(posedge i_clk or posedge i_reset)
		if (i_reset)
		begin
			out_cnt <= 3'h0;
			out_sh  <= 7'h00;
			o_so    <= 1'b0;
		end
		else if (cs_fall)
			out_cnt <= 3'h0;
		else if (out_load)
		begin
			out_cnt <= out_cnt + 1'b1;
			o_so    <= out_byte[7];
			out_sh  <= out_byte[6:0];
		end
		else if (sck_fall && out_state)
		begin
			out_cnt <= out_cnt + 1'b1;
			o_so    <= out_sh[6];
			out_sh  <= {out_sh[5:0], 1'b0};
		end

	// Output enable and standby indication.
	always_ff @(posedge i_clk or posedge i_reset)
		if (i_reset)
		begin
			o_so_oe   <= 1'b0;
			o_standby <= 1'b1;
		end
		else
		begin
			o_so_oe   <= sel & out_state;
			// A write starting on this select rise keeps standby off.
			o_standby <= i_cs_n & ~busy & ~commit_write
			           & ~commit_sr;
		end

	// ----------------------------------------------------------------
	// Buffer and programmer
	// ----------------------------------------------------------------
	sep_fifo2 u_fifo (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_fill  (fill_if),
		.o_drain (load_if)
	);

	sep_prog #(
		.WRITE_CYCLES (WRITE_CYCLES)
	) u_prog (
		.i_clk     (i_clk),
		.i_reset   (i_reset),
		.i_load    (load_if),
		.i_base    (addr[ADDR_W-1:PAGE_W]),
		.i_start   (commit_write | commit_sr),
		.i_abort   (abort_write),
		.i_rd_addr (addr),
		.o_rd_data (rd_data),
		.o_busy    (busy),
		.o_done    (done)
	);
endmodule : sep_eeprom
`default_nettype wire

// ---- verif/sep_eeprom_properties.sv ----
/*
 * Pin-level checker for the serial EEPROM block.
 * Assumes it is bound into sep_eeprom and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module sep_props #(
	parameter int WRITE_CYCLES = 100
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_cs_n,
	input wire logic i_sck,
	input wire logic i_si,
	input wire logic i_wp_n,
	input wire logic o_so,
	input wire logic o_so_oe,
	input wire logic o_standby
);
	int cnt;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// Counts deselected cycles spent out of standby.
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			cnt <= 0;
		else
			cnt <= (i_cs_n && !o_standby) ? cnt + 1 : 0;
	end
	property p_oe_off;
		i_cs_n && $past(i_cs_n) |-> !o_so_oe;
	endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("output driven while deselected");
	property p_sel_oe;
		o_so_oe |-> !$past(i_cs_n);
	endproperty
	a_sel_oe: assert property (p_sel_oe)
		else $error("output enabled without select");
	property p_oe_hold;
		o_so_oe && !i_cs_n |=> o_so_oe;
	endproperty
	a_oe_hold: assert property (p_oe_hold)
		else $error("output dropped inside selection");
	property p_sel_stby;
		$past(!i_cs_n) |-> !o_standby;
	endproperty
	a_sel_stby: assert property (p_sel_stby)
		else $error("standby while selected");
	property p_stby_hold;
		o_standby && $past(o_standby) && i_cs_n |=> o_standby;
	endproperty
	a_stby_hold: assert property (p_stby_hold)
		else $error("standby left while deselected");
	property p_so_fall;
		o_so_oe && $past(o_so_oe) && $changed(o_so) |-> !$past(i_sck)
			&& ($past(i_sck, 2) || $past(i_sck, 3));
	endproperty
	a_so_fall: assert property (p_so_fall)
		else $error("serial output moved off a falling edge");
	property p_oe_rise;
		$rose(o_so_oe) |-> $past(i_sck) && !$past(i_cs_n);
	endproperty
	a_oe_rise: assert property (p_oe_rise)
		else $error("output enabled off a rising edge");
	property p_wc_max;
		cnt <= WRITE_CYCLES + 8;
	endproperty
	a_wc_max: assert property (p_wc_max)
		else $error("write cycle too long");
	c_read: cover property ($rose(o_so_oe));
	c_prog: cover property (cnt == WRITE_CYCLES);
	c_wake: cover property ($fell(o_standby));
endmodule : sep_props
bind sep_eeprom sep_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
	.i_clk(i_clk), .i_reset(i_reset), .i_cs_n(i_cs_n), .i_sck(i_sck),
	.i_si(i_si), .i_wp_n(i_wp_n), .o_so(o_so), .o_so_oe(o_so_oe),
	.o_standby(o_standby));
`default_nettype wire

// ---- verif/sep_host.sv ----
/*
 * Model of the host controller on the serial link, mode 0.
 * Assumes its tasks are entered just after a falling clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module sep_host (
	input  wire logic i_clk,
	input  wire logic i_so,
	output var logic  o_cs_n,
	output var logic  o_sck,
	output var logic  o_si
);
	int half = 4;
	// Link idles deselected with the clock still.
	initial
	begin
		o_cs_n = 1'b1;
		o_sck = 1'b0;
		o_si = 1'b0;
	end
	// Selects the device ahead of the first clock.
	task automatic sel();
		o_cs_n = 1'b0;
		@(negedge i_clk);
	endtask : sel
	// Deselects after a half period of clock low, then waits two cycles.
	task automatic desel();
		repeat (half) @(negedge i_clk);
		o_cs_n = 1'b1;
		repeat (2) @(negedge i_clk);
	endtask : desel
	// Shifts n bits out MSB first and captures the reply.
	task automatic xb(input logic [7:0] tx, output logic [7:0] rx,
		input int n);
		rx = 8'h00;
		for (int i = 7; i >= 8 - n; i--)
		begin
			o_sck = 1'b0;
			o_si = tx[i];
			repeat (half) @(negedge i_clk);
			rx[i] = i_so;
			o_sck = 1'b1;
			repeat (half) @(negedge i_clk);
		end
		o_sck = 1'b0;
		o_si = ~tx[8-n];
	endtask : xb
endmodule : sep_host
`default_nettype wire

// ---- verif/tb_top.sv ----
/*
 * Self-checking bench for the serial EEPROM block.
 * Assumes the host model and checker files are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int WC = 400;
	logic i_clk, i_reset, i_wp_n, cs_n, sck, si, so, so_oe, stby;
	logic [7:0] rx;
	logic [7:0] sv [3] = '{8'h84, 8'h88, 8'h80};
	logic [15:0] lo [3] = '{16'h17FF, 16'h0FFF, 16'h0FFF};
	int num_errors = 0;
	int total_checks = 0;
	wire so_pin = so_oe ? so : ~so;
	sep_eeprom #(.WRITE_CYCLES(WC)) dut (.i_clk(i_clk), .i_reset(i_reset),
		.i_cs_n(cs_n), .i_sck(sck), .i_si(si), .i_wp_n(i_wp_n),
		.o_so(so), .o_so_oe(so_oe), .o_standby(stby));
	sep_host h (.i_clk(i_clk), .i_so(so_pin), .o_cs_n(cs_n),
		.o_sck(sck), .o_si(si));
	always #12.5 i_clk = ~i_clk;
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	task automatic chk(input string n, input logic [7:0] s, e);
		total_checks++;
		if (s !== e)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic b(input logic [7:0] v);
		h.xb(v, rx, 8);
	endtask : b
	task automatic op(input logic [7:0] v);
		h.sel();
		b(v);
		h.desel();
	endtask : op
	task automatic st(input logic [7:0] e);
		h.sel();
		b(8'h05);
		b(8'h00);
		h.desel();
		chk("status", rx, e);
	endtask : st
	task automatic idle();
		int n;
		n = 0;
		while (stby !== 1'b1 && n < 4 * WC)
		begin
			@(negedge i_clk);
			n++;
		end
		chk("standby", {7'h00, stby}, 8'h01);
	endtask : idle
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		op(8'h06);
		h.sel();
		b(8'h02);
		b(a[15:8]);
		b(a[7:0]);
		b(d);
		h.desel();
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		h.sel();
		b(8'h03);
		b(a[15:8]);
		b(a[7:0]);
		b(8'h00);
		h.desel();
		chk("data", rx, e);
	endtask : rd
	task automatic ws(input logic [7:0] v);
		op(8'h06);
		h.sel();
		b(8'h01);
		b(v);
		h.desel();
		idle();
	endtask : ws
	// Watchdog cuts a hang short.
	initial
	begin
		repeat (60000) @(posedge i_clk);
		num_errors++;
		complete_run();
	end
	// Main sequence of tests.
	initial
	begin
		i_clk = 1'b0;
		i_reset = 1'b1;
		i_wp_n = 1'b1;
		repeat (5) @(negedge i_clk);
		i_reset = 1'b0;
		chk("oe", {7'h00, so_oe}, 8'h00);
		st(8'h00);
		$display("test power-up done");
		op(8'h06);
		st(8'h02);
		op(8'h04);
		st(8'h00);
		h.sel();
		b(8'h06);
		b(8'h02);
		h.desel();
		st(8'h00);
		$display("test latch done");
		wr(16'hFFFF, 8'hA5);
		st(8'h03);
		h.sel();
		b(8'h03);
		b(8'h00);
		b(8'h00);
		b(8'h00);
		chk("busy oe", {7'h00, so_oe}, 8'h00);
		h.desel();
		idle();
		st(8'h00);
		wr(16'h0000, 8'h3C);
		idle();
		h.half = 6;
		h.sel();
		b(8'h03);
		b(8'hFF);
		b(8'hFF);
		b(8'h00);
		chk("seq0", rx, 8'hA5);
		b(8'h00);
		chk("seq1", rx, 8'h3C);
		h.desel();
		h.half = 4;
		$display("test byte write and read done");
		op(8'h06);
		h.sel();
		b(8'h02);
		b(8'h00);
		b(8'h3E);
		b(8'h11);
		b(8'h22);
		b(8'h33);
		h.desel();
		idle();
		rd(16'h003E, 8'h11);
		rd(16'h003F, 8'h22);
		rd(16'h0000, 8'h33);
		op(8'h06);
		h.sel();
		b(8'h02);
		b(8'h00);
		b(8'h00);
		b(8'h55);
		h.xb(8'h44, rx, 4);
		h.desel();
		idle();
		rd(16'h0000, 8'h33);
		op(8'h04);
		$display("test page write done");
		ws(8'hFF);
		st(8'h8C);
		wr(16'h0000, 8'h77);
		idle();
		rd(16'h0000, 8'h33);
		i_wp_n = 1'b0;
		op(8'h06);
		ws(8'h00);
		st(8'h8E);
		i_wp_n = 1'b1;
		h.sel();
		b(8'h01);
		b(8'h00);
		i_wp_n = 1'b0;
		@(negedge i_clk);
		i_wp_n = 1'b1; // Lock is gone again before select rises.
		h.desel();
		idle();
		st(8'h8E);
		$display("test status protect done");
		for (int k = 0; k < 3; k++)
		begin
			ws(sv[k]);
			wr(16'h1FFF, 8'h5A);
			idle();
			rd(16'h1FFF, k < 2 ? 8'hA5 : 8'h5A);
			wr(lo[k], 8'hC0);
			idle();
			rd(lo[k], 8'hC0);
		end
		$display("test block protect done");
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
